// ### rtl/ptx_consts.svh
// shared offsets, field positions and widths for the transmit lane
`ifndef PTX_CONSTS_SVH
`define PTX_CONSTS_SVH
`define PTX_WORD_W      20
`define PTX_SYM_W       10
`define PTX_BYTE_W      8
`define PTX_LO_BYTE_MSB 7
`define PTX_LO_K_BIT    8
`define PTX_HI_BYTE_LSB 10
`define PTX_HI_K_BIT    18
`define PTX_NARROW_MASK 20'h3_FCFF
`define PTX_MAX_BOND    12
`define PTX_K28_CODE    5'h1C
`define PTX_RD_RESET    1'b0
`endif

// ### rtl/ptx_pkg.sv
// types shared by the transmit lane modules
package ptx_pkg;
    // fabric word width mode
    typedef enum logic [1:0] {
        PTX_M8  = 2'b00,
        PTX_M16 = 2'b01,
        PTX_M10 = 2'b10,
        PTX_M20 = 2'b11
    } ptx_mode_e;
    // where the reversal unit sits
    typedef enum logic [1:0] {
        PTX_BYPASS = 2'b00,
        PTX_PRE    = 2'b01,
        PTX_POST   = 2'b10
    } ptx_rsel_e;
endpackage

// ### rtl/ptx_reverser.sv
// polarity, bit order and byte order reversal of one 20-bit lane word
`timescale 1ns/100ps
`default_nettype none
`include "ptx_consts.svh"
module ptx_reverser
    import ptx_pkg::*;
(
    // word path
    input  wire logic [19:0] word_in,
    output logic      [19:0] word_out,
    // configuration
    input  wire logic        wide,
    input  wire logic        dual,
    input  wire logic        pol_en,
    input  wire logic        bitrev_en,
    input  wire logic        swap_en
);
    logic [19:0] mask;  // bits touched by inversion
    logic [19:0] inv;   // after polarity
    logic [19:0] rev;   // after bit order

    // reverse each 10-bit half, whole symbol or only its byte
    function automatic logic [19:0] mirror(input logic [19:0] w, input logic full);
        logic [19:0] r;
        r = w;
        for (int h = 0; h < 2; h++) begin
            for (int b = 0; b < 10; b++) begin
                if (full) begin
                    r[h*10+b] = w[h*10+9-b];
                end else if (b < 8) begin
                    r[h*10+b] = w[h*10+7-b];
                end
            end
        end
        return r;
    endfunction

    // combinational: invert, then mirror, then exchange halves
    always_comb begin
        mask = wide ? 20'hF_FFFF : `PTX_NARROW_MASK;
        if (!dual) begin
            mask[19:10] = 10'h000; // upper half idle in single-symbol modes
        end
        inv = pol_en ? (word_in ^ mask) : word_in;
        rev = bitrev_en ? mirror(inv, wide) : inv;
        if (swap_en && dual) begin
            word_out = {rev[9:0], rev[19:10]};
        end else begin
            word_out = rev;
        end
    end
endmodule
`default_nettype wire

// ### rtl/ptx_enc8b10b.sv
// one 8b/10b encoder: byte plus control flag to a 10-bit code group
`timescale 1ns/100ps
`default_nettype none
`include "ptx_consts.svh"
module ptx_enc8b10b
    import ptx_pkg::*;
(
    // byte in
    input  wire logic [7:0] data,
    input  wire logic       k,
    input  wire logic       rd_in,
    // code group out
    output logic      [9:0] code,
    output logic            rd_out,
    output logic            k_bad
);
    // 6-bit sub-block for negative disparity, written abcdei (a leftmost)
    localparam logic [5:0] T6 [32] = '{
        6'b100111, 6'b011101, 6'b101101, 6'b110001, 6'b110101, 6'b101001, 6'b011001, 6'b111000,
        6'b111001, 6'b100101, 6'b010101, 6'b110100, 6'b001101, 6'b101100, 6'b011100, 6'b010111,
        6'b011011, 6'b100011, 6'b010011, 6'b110010, 6'b001011, 6'b101010, 6'b011010, 6'b111010,
        6'b110011, 6'b100110, 6'b010110, 6'b110110, 6'b001110, 6'b101110, 6'b011110, 6'b101011};
    // 4-bit data sub-block for negative disparity, written fghj
    localparam logic [3:0] T4D [8] = '{4'b1011, 4'b1001, 4'b0101, 4'b1100,
                                       4'b1101, 4'b1010, 4'b0110, 4'b1110};
    // 4-bit control sub-block after a positive 6-bit result
    localparam logic [3:0] T4K [8] = '{4'b0100, 4'b1001, 4'b0101, 4'b0011,
                                       4'b0010, 4'b1010, 4'b0110, 4'b1000};

    logic [4:0] x;   // low five data bits
    logic [2:0] y;   // high three data bits
    logic [5:0] s6;  // 6-bit sub-block
    logic [3:0] s4;  // 4-bit sub-block
    logic       mid; // disparity between the sub-blocks

    // the code words are written a-first, the output wants a at bit 0
    function automatic logic [5:0] rev6(input logic [5:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5]};
    endfunction
    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction

    // combinational encode, disparity chains through both sub-blocks
    always_comb begin
        x  = data[4:0];
        y  = data[7:5];
        s6 = (k && x == `PTX_K28_CODE) ? 6'b001111 : T6[x];
        // flip unbalanced blocks, and D.07, when running positive
        if (rd_in && ($countones(s6) != 3 || s6 == 6'b111000)) begin
            s6 = ~s6;
        end
        mid = ($countones(s6) != 3) ? ~rd_in : rd_in;
        if (k) begin
            s4 = mid ? T4K[y] : ~T4K[y];
        end else begin
            s4 = T4D[y];
            // alternate x.7 keeps runs at five bits or less
            if (y == 3'd7 && ((!mid && x inside {5'd17, 5'd18, 5'd20}) ||
                              (mid && x inside {5'd11, 5'd13, 5'd14}))) begin
                s4 = 4'b0111;
            end
            if (mid && ($countones(s4) != 2 || s4 == 4'b1100)) begin
                s4 = ~s4;
            end
        end
        rd_out = ($countones(s4) != 2) ? ~mid : mid;
        code   = {rev4(s4), rev6(s6)};
        // only K28.y and K23/27/29/30.7 name control symbols
        k_bad  = k && !(x == `PTX_K28_CODE ||
                        (y == 3'd7 && x inside {5'd23, 5'd27, 5'd29, 5'd30}));
    end
endmodule
`default_nettype wire

// ### rtl/ptx_lane.sv
// transmit lane: optional reversal, 8b/10b encoding, word to serializer
`timescale 1ns/100ps
`default_nettype none
`include "ptx_consts.svh"
module ptx_lane
    import ptx_pkg::*;
#(
    parameter int BOND_LANES = 1, // lanes in this bonded group
    parameter int LANE_INDEX = 0  // this lane's place in the group
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // fabric word
    input  wire logic        tx_valid,
    input  wire logic [19:0] tx_data,
    // configuration
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  rev_sel,
    input  wire logic        pol_en,
    input  wire logic        bitrev_en,
    input  wire logic        swap_en,
    input  wire logic        rd_restart,
    // to serializer
    output logic      [19:0] ser_data,
    output logic             ser_valid,
    // status
    output logic             ctrl_err,
    output logic             comma_sent,
    output logic             rd_state,
    output logic             bond_lead
);
    // refuse group sizes the bonding fabric cannot carry, at elaboration
    if (BOND_LANES < 1 || BOND_LANES > `PTX_MAX_BOND) begin : g_bad_bond
        $error("bond group size out of range");
    end
    // a lane outside its own group could never see the shared restart
    if (LANE_INDEX < 0 || LANE_INDEX >= BOND_LANES) begin : g_bad_index
        $error("lane index outside bond group");
    end

    ptx_mode_e   mode_q;      // decoded width mode
    ptx_rsel_e   rsel_q;      // decoded reversal placement
    logic        encode;      // byte modes go through the encoders
    logic        dual;        // two symbols per word
    logic [19:0] pre_word;    // after the pre-encode reverser
    logic [19:0] pre_sel;     // pre reverser result or raw input
    logic [19:0] enc_word;    // encoded or raw symbols
    logic [19:0] post_word;   // after the post-encode reverser
    logic [19:0] out_word;    // word bound for the serializer
    logic [2:0]  rd_chain;    // disparity: carried in, low out, high out
    logic [1:0]  k_bad;       // per-byte bad control value
    logic [1:0]  is_comma;    // per-byte comma symbol
    logic [19:0] code;        // both encoder outputs
    logic        rd;          // running disparity held between words
    logic        next_rd;
    logic [19:0] next_ser_data;
    logic        next_ser_valid;
    logic        next_ctrl_err;
    logic        next_comma_sent;

    // decode the configuration buses; unused placement code means bypass
    function automatic ptx_rsel_e dec_rsel(input logic [1:0] v);
        unique case (v)
            2'b01:   return PTX_PRE;
            2'b10:   return PTX_POST;
            default: return PTX_BYPASS;
        endcase
    endfunction

    // comma test on the encoder input byte: K28.1, K28.5 and K28.7
    function automatic logic comma_byte(input logic [7:0] b, input logic k);
        return k && b[4:0] == `PTX_K28_CODE &&
               (b[7:5] == 3'd1 || b[7:5] == 3'd5 || b[7:5] == 3'd7);
    endfunction

    assign mode_q = ptx_mode_e'(mode);
    assign rsel_q = dec_rsel(rev_sel);
    // generic lane: 8b/10b is the only encoder, raw modes bypass it
    assign encode = (mode_q == PTX_M8) || (mode_q == PTX_M16);
    assign dual   = (mode_q == PTX_M16) || (mode_q == PTX_M20);

    // pre-encode reverser sees byte layout in byte modes
    ptx_reverser u_pre (
        .word_in   (tx_data),
        .word_out  (pre_word),
        .wide      (!encode),
        .dual      (dual),
        .pol_en    (pol_en),
        .bitrev_en (bitrev_en),
        .swap_en   (swap_en)
    );

    // only one reverser may act at once, the other passes through
    assign pre_sel = (rsel_q == PTX_PRE) ? pre_word : tx_data;

    // cascaded encoders, byte 0 first, disparity flows low to high
    assign rd_chain[0] = rd;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_enc
            ptx_enc8b10b u_enc (
                .data   (pre_sel[g*10 +: 8]),
                .k      (pre_sel[g*10 + 8]),
                .rd_in  (rd_chain[g]),
                .code   (code[g*10 +: 10]),
                .rd_out (rd_chain[g+1]),
                .k_bad  (k_bad[g])
            );
            assign is_comma[g] = comma_byte(pre_sel[g*10 +: 8], pre_sel[g*10 + 8]);
        end
    endgenerate

    // pick encoded or raw symbols; single-symbol modes clear the top half
    always_comb begin
        if (encode) begin
            enc_word = dual ? code : {10'h000, code[9:0]};
        end else begin
            enc_word = dual ? pre_sel : {10'h000, pre_sel[9:0]};
        end
    end

    // post-encode reverser always sees full symbols
    ptx_reverser u_post (
        .word_in   (enc_word),
        .word_out  (post_word),
        .wide      (1'b1),
        .dual      (dual),
        .pol_en    (pol_en),
        .bitrev_en (bitrev_en),
        .swap_en   (swap_en)
    );

    assign out_word = (rsel_q == PTX_POST) ? post_word : enc_word;

    // next disparity and output word
    always_comb begin
        next_rd         = rd;
        next_ser_data   = ser_data;
        next_ser_valid  = tx_valid;
        next_ctrl_err   = 1'b0;
        next_comma_sent = 1'b0;
        if (rd_restart) begin
            // whole bond group restarts together from negative disparity
            next_rd = `PTX_RD_RESET;
        end else if (tx_valid && encode) begin
            next_rd = dual ? rd_chain[2] : rd_chain[1];
        end
        if (tx_valid) begin
            next_ser_data = out_word;
            if (encode) begin
                // the fabric broke its side: flag a bad control value
                next_ctrl_err   = k_bad[0] || (dual && k_bad[1]);
                next_comma_sent = is_comma[0] || (dual && is_comma[1]);
            end
        end
    end

    // register disparity and every output but bond_lead; data holds when idle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd         <= `PTX_RD_RESET;
            ser_data   <= 20'h0_0000;
            ser_valid  <= 1'b0;
            ctrl_err   <= 1'b0;
            comma_sent <= 1'b0;
        end else begin
            rd         <= next_rd;
            ser_data   <= next_ser_data;
            ser_valid  <= next_ser_valid;
            ctrl_err   <= next_ctrl_err;
            comma_sent <= next_comma_sent;
        end
    end

    assign rd_state  = rd;
    // lane zero leads the group when disparity restarts are shared
    assign bond_lead = (LANE_INDEX == 0);
endmodule
`default_nettype wire

// ### testbench/ptx_lane_checker.sv
// port-level assertions for the transmit lane
`timescale 1ns/100ps
`default_nettype none
module ptx_lane_checker
    import ptx_pkg::*;
#(
    parameter int LANE_INDEX = 0 // place in the bond group
)
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // fabric word and options
    input wire logic        tx_valid,
    input wire logic [19:0] tx_data,
    input wire logic [1:0]  mode,
    input wire logic [1:0]  rev_sel,
    input wire logic        pol_en,
    input wire logic        bitrev_en,
    input wire logic        swap_en,
    input wire logic        rd_restart,
    // serializer side and status
    input wire logic [19:0] ser_data,
    input wire logic        ser_valid,
    input wire logic        ctrl_err,
    input wire logic        comma_sent,
    input wire logic        rd_state,
    input wire logic        bond_lead
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic        raw_act; // raw 20-bit word through an active reverser
    logic [19:0] swapped; // halves exchanged
    logic [19:0] mirrored; // each symbol mirrored
    assign raw_act = tx_valid && mode == PTX_M20 && (rev_sel == 2'h1 || rev_sel == 2'h2);
    assign swapped = {tx_data[9:0], tx_data[19:10]};
    // per-symbol mirror, no flag bits in raw modes
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            mirrored[i] = tx_data[9 - i];
            mirrored[10 + i] = tx_data[19 - i];
        end
    end
    a_valid_follow: assert property (tx_valid |=> ser_valid)
        else $error("no output word after a taken word");
    a_idle_quiet: assert property (!tx_valid |=> !ser_valid && !comma_sent && !ctrl_err && $stable(ser_data))
        else $error("output moved without a taken word");
    a_upper_zero: assert property (tx_valid && !mode[0] |=> ser_data[19:10] == 10'h000)
        else $error("single-symbol mode upper half not zero");
    a_raw_bypass: assert property (tx_valid && mode == PTX_M20 && (rev_sel == 2'h0 || rev_sel == 2'h3)
        |=> ser_data == $past(tx_data))
        else $error("bypassed raw word altered");
    a_raw_invert: assert property (raw_act && pol_en && !bitrev_en && !swap_en |=> ser_data == ~$past(tx_data))
        else $error("raw polarity not full width");
    a_raw_swap: assert property (raw_act && !pol_en && !bitrev_en && swap_en |=> ser_data == $past(swapped))
        else $error("raw symbols not exchanged");
    a_raw_mirror: assert property (raw_act && !pol_en && bitrev_en && !swap_en |=> ser_data == $past(mirrored))
        else $error("raw symbols not mirrored");
    a_restart_neg: assert property (rd_restart |=> !rd_state)
        else $error("disparity not negative after restart");
    a_rd_hold: assert property (!tx_valid && !rd_restart |=> $stable(rd_state))
        else $error("disparity moved while idle");
    a_comma_pair: assert property (tx_valid && mode == PTX_M16 && rev_sel == 2'h0 && tx_data == 20'h6_F1BC
        && !rd_state |=> ser_data == 20'hA_0D7C && comma_sent ##1 !comma_sent || tx_valid)
        else $error("comma pair coded wrong");
    a_bond_lead: assert property (bond_lead == (LANE_INDEX == 0))
        else $error("group lead flag wrong");
endmodule
`default_nettype wire

// ### testbench/ptx_serial_model.sv
// serializer model: shifts words out and tracks the longest run
`timescale 1ns/100ps
`default_nettype none
module ptx_serial_model
(
    // clock and control
    input  wire logic        ref_clk,
    input  wire logic        clr,
    // lane word
    input  wire logic        ser_valid,
    input  wire logic [19:0] ser_data,
    input  wire logic        wide,
    // run statistic
    output var  int          max_run
);
    logic last;   // previous serial bit
    logic wide_q; // width of the word now on ser_data
    int   run;    // current run of equal bits
    // runs continue across word edges, as on the line
    always @(posedge ref_clk) begin
        if (clr) begin
            run = 0;
            max_run = 0;
        end else if (ser_valid) begin
            for (int i = 0; i < (wide_q ? 20 : 10); i++) begin // lsb first
                run = (run > 0 && ser_data[i] == last) ? run + 1 : 1;
                last = ser_data[i];
                if (run > max_run) max_run = run;
            end
        end
        wide_q <= wide;
    end
endmodule
`default_nettype wire

// ### testbench/ptx_lane_bench.sv
// self-checking bench of the transmit lane
`timescale 1ns/100ps
`default_nettype none
module ptx_lane_bench import ptx_pkg::*;;
    logic        ref_clk, rst_b, tx_valid;      // clock, reset, strobe
    logic [19:0] tx_data, ser_data;             // fabric and line words
    logic [1:0]  mode, rev_sel;                 // width and reverser place
    logic        pol_en, bitrev_en, swap_en;    // reverser options
    logic        rd_restart, model_clr, rd_e;   // restart, run clear, model disparity
    logic        ser_valid, ctrl_err, comma_sent, rd_state, bond_lead; // outputs
    logic [31:0] seed;                          // xorshift state
    int          max_run, n_fail, cmp_count;    // run statistic, counters
    ptx_lane #(.BOND_LANES(2), .LANE_INDEX(1)) i_ptx_lane (.ref_clk(ref_clk), .rst_b(rst_b),
        .tx_valid(tx_valid), .tx_data(tx_data), .mode(mode), .rev_sel(rev_sel), .pol_en(pol_en),
        .bitrev_en(bitrev_en), .swap_en(swap_en), .rd_restart(rd_restart), .ser_data(ser_data),
        .ser_valid(ser_valid), .ctrl_err(ctrl_err), .comma_sent(comma_sent), .rd_state(rd_state),
        .bond_lead(bond_lead));
    ptx_serial_model i_ptx_serial_model (.ref_clk(ref_clk), .clr(model_clr), .ser_valid(ser_valid),
        .ser_data(ser_data), .wide(mode[0]), .max_run(max_run));
    always #4 ref_clk = ~ref_clk;
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // raw modes: reverser alone decides the line word
    function automatic logic [19:0] rev_exp(input logic [1:0] m, rs, input logic [2:0] o, input logic [19:0] d);
        logic [19:0] w;
        logic [19:0] t;
        w = (o[2] && rs inside {2'h1, 2'h2}) ? ~d : d;
        t = w;
        for (int i = 0; i < 10; i++) begin
            if (o[1] && rs inside {2'h1, 2'h2}) {w[i], w[10 + i]} = {t[9 - i], t[19 - i]};
        end
        if (o[0] && m[0] && rs inside {2'h1, 2'h2}) w = {w[9:0], w[19:10]};
        if (!m[0]) w[19:10] = 10'h000;
        return w;
    endfunction
    // inputs move at the falling edge only
    task automatic send(input logic [1:0] m, rs, input logic [2:0] o, input logic [19:0] d);
        {mode, rev_sel, pol_en, bitrev_en, swap_en, tx_data} = {m, rs, o, d};
        {tx_valid, rd_restart} = 2'b10;
        @(negedge ref_clk);
    endtask
    task automatic idle(input logic r);
        {tx_valid, rd_restart} = {1'b0, r};
        @(negedge ref_clk);
    endtask
    // one word from negative disparity, flags {error, comma}
    task automatic known(input logic [1:0] m, rs, input logic [2:0] o, input logic [19:0] d, e, input logic [1:0] f);
        idle(1'b1);
        send(m, rs, o, d);
        check(ser_data, e);
        check({18'h0_0000, ctrl_err, comma_sent}, {18'h0_0000, f});
    endtask
    // a symbol of six ones only from negative, of four only from positive
    task automatic sym(input logic [9:0] s);
        int n;
        n = $countones(s);
        check(20'(n >= 4 && n <= 6), 20'h0_0001);
        if (n != 5) begin
            check(20'(rd_e), 20'(n == 4));
            rd_e = ~rd_e;
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic [19:0] d;
        {ref_clk, rst_b, tx_valid, pol_en, bitrev_en, swap_en, rd_restart, model_clr} = 8'h01;
        {tx_data, mode, rev_sel, n_fail, cmp_count, rd_e} = '0;
        seed = 32'h0000_0039;
        repeat (3) @(negedge ref_clk);
        check(ser_data, 20'h0_0000);
        check({16'h0, ser_valid, ctrl_err, comma_sent, rd_state}, 20'h0_0000);
        rst_b = 1'b1;
        check(20'(bond_lead), 20'h0_0000); // follower lane of a group
        known(PTX_M16, 2'h0, 3'h0, 20'h6_F1BC, 20'hA_0D7C, 2'h1); // comma pair, flags at 8 and 18
        known(PTX_M16, 2'h1, 3'h4, 20'h5_0D43, 20'hA_0D7C, 2'h1); // inverted before coding, flags kept
        known(PTX_M16, 2'h1, 3'h2, 20'h4_F53D, 20'hA_0D7C, 2'h1); // mirrored bytes before coding
        known(PTX_M16, 2'h2, 3'h4, 20'h6_F1BC, 20'h5_F283, 2'h1); // inverted after coding
        known(PTX_M16, 2'h2, 3'h2, 20'h6_F1BC, 20'hC_14FA, 2'h1); // msb first after coding
        known(PTX_M16, 2'h1, 3'h1, 20'h6_F1FC, 20'hE_0D7C, 2'h1); // byte swap, high byte first
        known(PTX_M16, 2'h0, 3'h1, 20'h6_F1FC, 20'h5_F07C, 2'h1); // swap unused while bypassed
        known(PTX_M8, 2'h0, 3'h0, 20'h0_01B5, 20'h0_0295, 2'h2); // bad flag, coded via control table
        known(PTX_M8, 2'h0, 3'h0, 20'h0_01BC, 20'h0_017C, 2'h1); // single comma
        // raw words with every reverser place and option mix
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            d = rnd();
            send({1'b1, r[0]}, r[2:1], r[5:3], d);
            check(ser_data, rev_exp({1'b1, r[0]}, r[2:1], r[5:3], d));
            if (r[6]) idle(1'b0);
        end
        // coded bytes, flags clear, disparity followed symbol by symbol
        idle(1'b1);
        model_clr = 1'b0;
        rd_e = 1'b0;
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            send({1'b0, r[0]}, {2{r[19]}}, r[18:16], {2'h0, r[15:8], 2'h0, r[7:0]});
            sym(ser_data[9:0]);
            if (r[0]) sym(ser_data[19:10]);
            check(20'(rd_state), 20'(rd_e));
            if (r[7]) idle(1'b0);
        end
        idle(1'b0);
        check(20'(max_run > 0 && max_run <= 5), 20'h0_0001);
        end_of_test();
    end
endmodule
bind ptx_lane ptx_lane_checker #(.LANE_INDEX(LANE_INDEX)) i_ptx_lane_checker (.ref_clk(ref_clk), .rst_b(rst_b),
    .tx_valid(tx_valid), .tx_data(tx_data), .mode(mode), .rev_sel(rev_sel), .pol_en(pol_en),
    .bitrev_en(bitrev_en), .swap_en(swap_en), .rd_restart(rd_restart), .ser_data(ser_data),
    .ser_valid(ser_valid), .ctrl_err(ctrl_err), .comma_sent(comma_sent), .rd_state(rd_state),
    .bond_lead(bond_lead));
`default_nettype wire
